// >>> design/step_dir_microstep_sequencer.sv
/*
  Step and direction front end of a two-phase stepper driver: synchronised
  step and direction inputs, 10-bit microstep position, optional 16x
  interpolator, standstill detection and sine/cosine coil targets.
  Assumes a single 20 MHz ref_clk and a plain register port with
  read data one cycle after the read strobe.
*/
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module step_dir_microstep_sequencer #(
    parameter int STANDSTILL_CYCLES = stepdir_pkg::STANDSTILL_CYC
) (
    // Clock and reset
    input  wire logic                            ref_clk,
    input  wire logic                            arst_n,
    // Register port
    input  wire logic [stepdir_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [stepdir_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [stepdir_pkg::DATA_W-1:0]  reg_rdata,
    // Step and direction pins
    input  wire logic                            step_in,
    input  wire logic                            dir_in,
    // Standalone configuration
    input  wire logic                            half_current_standstill,
    // Coil targets and status
    output stepdir_pkg::coil_s                   coil,
    output logic      [stepdir_pkg::POS_W-1:0]   microstep_position,
    output logic                                 standstill_flag
);

    // ==========================================================
    // Declarations
    stepdir_pkg::ctrl_s                      drive_control_register;
    logic [1:0]                              sync_q;
    logic                                    step_s;
    logic                                    dir_s;
    logic                                    step_prev_reg;
    logic                                    active_edge;
    logic [9:0]                              step_size;
    logic [4:0]                              pending_reg;
    logic                                    pend_dir_reg;
    logic [stepdir_pkg::INTERVAL_W-1:0]      interval_reg;
    logic [stepdir_pkg::INTERVAL_W-1:0]      tmr_reg;
    logic [stepdir_pkg::PERIOD_W-1:0]        period_reg;
    logic [stepdir_pkg::PERIOD_W-1:0]        period_div;
    logic [stepdir_pkg::IDLE_W-1:0]          idle_reg;
    logic                                    tick;
    logic signed [8:0]                       sine_a;
    logic signed [8:0]                       sine_b;
    logic                                    halve;

    assign step_s = sync_q[0];
    assign dir_s  = sync_q[1];

    // ==========================================================
    // Input synchronisation
    // Glitch filtering is left to the pads; only metastability is handled here
    input_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk    (ref_clk),
        .arst_n (arst_n),
        .d      ({dir_in, step_in}),
        .q      (sync_q)
    );

    // Previous synchronised step level for edge detection
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            step_prev_reg <= 1'b0;
        end else begin
            step_prev_reg <= step_s;
        end
    end

    // Active edge selection
    always_comb begin
        if (drive_control_register.dual_edge) begin
            active_edge = step_s ^ step_prev_reg;
        end else begin
            active_edge = step_s & ~step_prev_reg;
        end
    end

    // ==========================================================
    // Register port
    // Drive control register written by software
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_control_register <= '{res: stepdir_pkg::RES_RESET,
                                        interp: 1'b0, dual_edge: 1'b0};
        end else if (reg_wr && reg_addr == stepdir_pkg::ADDR_CTRL) begin
            drive_control_register.dual_edge <= reg_wdata[stepdir_pkg::CTRL_DUAL_EDGE_BIT];
            drive_control_register.interp    <= reg_wdata[stepdir_pkg::CTRL_INTERP_BIT];
            drive_control_register.res       <=
                reg_wdata[stepdir_pkg::CTRL_RES_LSB +: stepdir_pkg::RES_W];
        end
    end

    // Read data stands for one cycle only; unmapped reads give zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_rd && reg_addr == stepdir_pkg::ADDR_CTRL) begin
                reg_rdata[stepdir_pkg::CTRL_DUAL_EDGE_BIT] <= drive_control_register.dual_edge;
                reg_rdata[stepdir_pkg::CTRL_INTERP_BIT] <= drive_control_register.interp;
                reg_rdata[stepdir_pkg::CTRL_RES_LSB +: stepdir_pkg::RES_W] <=
                    drive_control_register.res;
            end else if (reg_rd && reg_addr == stepdir_pkg::ADDR_STATUS) begin
                reg_rdata[stepdir_pkg::STAT_STANDSTILL_BIT] <= standstill_flag;
                reg_rdata[stepdir_pkg::STAT_POS_LSB +: stepdir_pkg::POS_W] <=
                    microstep_position;
            end
        end
    end

    // ==========================================================
    // Step size from resolution: 256 >> res, codes above 8 give 1
    always_comb begin
        if (drive_control_register.res > stepdir_pkg::RES_FINEST) begin
            step_size = 10'h001;
        end else begin
            step_size = stepdir_pkg::FULLSTEP_SIZE >> drive_control_register.res;
        end
    end

    // ==========================================================
    // Interpolator
    // Microstep due when the interval timer has run its course
    assign tick = (pending_reg != 5'h00) && (tmr_reg >= interval_reg);

    // Period since last active edge, saturating so interval stays capped
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            period_reg <= '1;
        end else if (active_edge) begin
            period_reg <= {{(stepdir_pkg::PERIOD_W-1){1'b0}}, 1'b1};
        end else if (period_reg != '1) begin
            period_reg <= period_reg + 1'b1;
        end
    end

    assign period_div = period_reg >> stepdir_pkg::INTERP_SHIFT;

    // Interval latched from the period just finished, used for the next one
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            interval_reg <= '1;
        end else if (active_edge) begin
            if (period_div[stepdir_pkg::INTERVAL_W-1:0] == '0) begin
                interval_reg <= {{(stepdir_pkg::INTERVAL_W-1){1'b0}}, 1'b1};
            end else begin
                interval_reg <= period_div[stepdir_pkg::INTERVAL_W-1:0];
            end
        end
    end

    // Interval timer restarts on every edge and every microstep
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tmr_reg <= '0;
        end else if (active_edge || tick) begin
            tmr_reg <= {{(stepdir_pkg::INTERVAL_W-1){1'b0}}, 1'b1};
        end else if (tmr_reg != '1) begin
            tmr_reg <= tmr_reg + 1'b1;
        end
    end

    // Outstanding microsteps and their direction
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_reg  <= 5'h00;
            pend_dir_reg <= 1'b0;
        end else if (!drive_control_register.interp) begin
            pending_reg  <= 5'h00;
        end else if (active_edge) begin
            pending_reg  <= stepdir_pkg::INTERP_LOAD;
            pend_dir_reg <= dir_s;
        end else if (tick) begin
            pending_reg  <= pending_reg - 5'h01;
        end
    end

    // ==========================================================
    // Microstep position
    // An early edge first completes the unfinished step: a small jump
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            microstep_position <= '0;
        end else if (active_edge && drive_control_register.interp) begin
            if (pend_dir_reg) begin
                microstep_position <= microstep_position - {5'h00, pending_reg};
            end else begin
                microstep_position <= microstep_position + {5'h00, pending_reg};
            end
        end else if (active_edge) begin
            if (dir_s) begin
                microstep_position <= microstep_position - step_size;
            end else begin
                microstep_position <= microstep_position + step_size;
            end
        end else if (tick) begin
            if (pend_dir_reg) begin
                microstep_position <= microstep_position - 10'h001;
            end else begin
                microstep_position <= microstep_position + 10'h001;
            end
        end
    end

    // ==========================================================
    // Standstill detection
    // Last count of the idle window; declared before the counter that uses it
    localparam logic [stepdir_pkg::IDLE_W-1:0] IDLE_MAX =
        stepdir_pkg::IDLE_W'(STANDSTILL_CYCLES - 1);

    // Idle counter saturates so a long stop cannot wrap and drop the flag
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_reg <= '0;
        end else if (active_edge) begin
            idle_reg <= '0;
        end else if (idle_reg != IDLE_MAX) begin
            idle_reg <= idle_reg + 1'b1;
        end
    end

    // Edge clears; no active edge for the full window sets
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            standstill_flag <= 1'b0;
        end else if (active_edge) begin
            standstill_flag <= 1'b0;
        end else if (idle_reg == IDLE_MAX) begin
            standstill_flag <= 1'b1;
        end
    end

    // ==========================================================
    // Coil targets: coil A sine, coil B cosine (quarter turn ahead)
    quarter_sine u_sine_a (
        .angle (microstep_position),
        .value (sine_a)
    );

    quarter_sine u_sine_b (
        .angle (microstep_position + stepdir_pkg::QUARTER_TURN),
        .value (sine_b)
    );

    assign halve = half_current_standstill & standstill_flag;

    // Registered targets, halved at standstill when strapped for it
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            coil <= '0;
        end else if (halve) begin
            coil.a <= sine_a >>> 1;
            coil.b <= sine_b >>> 1;
        end else begin
            coil.a <= sine_a;
            coil.b <= sine_b;
        end
    end

    // ==========================================================
    // Checks
    sequence edge_alone_s;
        active_edge && !drive_control_register.interp;
    endsequence

    chk_fall_ignored: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!step_s && step_prev_reg && !drive_control_register.dual_edge
         && pending_reg == 5'h00) |=> $stable(microstep_position))
        else $error("falling edge moved position in single-edge mode");

    chk_sync_delay: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(step_in) ##1 step_in |-> ##1 step_s)
        else $error("step level not seen two cycles after input");

    chk_step_up: assert property (@(posedge ref_clk) disable iff (!arst_n)
        edge_alone_s and !dir_s |=>
        microstep_position == $past(microstep_position) + $past(step_size))
        else $error("position not increased by step size");

    chk_step_down: assert property (@(posedge ref_clk) disable iff (!arst_n)
        edge_alone_s and dir_s |=>
        microstep_position == $past(microstep_position) - $past(step_size))
        else $error("position not decreased by step size");

    chk_step_pow2: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $onehot(step_size) && step_size <= stepdir_pkg::FULLSTEP_SIZE)
        else $error("step size not a power of two up to 256");

    chk_table_peak: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (microstep_position == 10'h100 && !halve) |=> coil.a == 9'sd248 && coil.b == -9'sd1)
        else $error("quarter turn does not give coil A peak");

    chk_half_turn: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (microstep_position == 10'h200 && !halve) |=> coil.b == -9'sd248 && coil.a == -9'sd1)
        else $error("half turn does not give coil B negative peak");

    chk_interp_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (active_edge && drive_control_register.interp) |=> pending_reg == 5'h10)
        else $error("interpolator not loaded with sixteen microsteps");

    chk_interp_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !drive_control_register.interp |=> pending_reg == 5'h00)
        else $error("microsteps pending while interpolation is off");

    chk_still_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (standstill_flag && active_edge) |=> !standstill_flag)
        else $error("standstill not cleared by active edge");

    chk_still_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (idle_reg == IDLE_MAX && !active_edge) |=> standstill_flag)
        else $error("standstill not set after idle window");

    // A microstep at interval three followed by two quiet cycles with no new edge
    sequence tick_gap_s;
        tick && !active_edge && interval_reg == 20'h00003 ##1 !active_edge [*2];
    endsequence

    chk_tick_space: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tick_gap_s |=> (tick || pending_reg == 5'h00) && !$past(tick) && !$past(tick, 2))
        else $error("microstep spacing differs from interval");

endmodule

// >>> design/stepdir_pkg.sv
/*
  Shared constants and types for the step and direction microstep sequencer:
  register offsets, field positions, reset values and interpolation counts.
  Assumes a single 20 MHz system clock; no other package is needed.
*/
package stepdir_pkg;

    // ==========================================================
    // Register map (byte offsets on the plain register port)
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;

    // ==========================================================
    // Drive control register fields
    localparam int          CTRL_DUAL_EDGE_BIT = 0;
    localparam int          CTRL_INTERP_BIT = 1;
    localparam int          CTRL_RES_LSB    = 4;
    localparam int          RES_W           = 4;
    localparam logic [3:0]  RES_RESET       = 4'h4;  // 16 positions per step
    localparam logic [3:0]  RES_FINEST      = 4'h8;  // 1 position per step

    // ==========================================================
    // Status register fields
    localparam int          STAT_STANDSTILL_BIT = 0;
    localparam int          STAT_POS_LSB    = 16;

    // ==========================================================
    // Position and interpolation
    localparam int          POS_W           = 10;
    localparam logic [9:0]  FULLSTEP_SIZE   = 10'h100;
    localparam logic [9:0]  QUARTER_TURN    = 10'h100;
    localparam int          INTERP_STEPS    = 16;
    localparam logic [4:0]  INTERP_LOAD     = 5'h10;
    localparam int          INTERP_SHIFT    = 4;     // divide period by 16
    localparam int          PERIOD_W        = 24;
    localparam int          INTERVAL_W      = 20;    // at most 2^20 cycles
    localparam int          STANDSTILL_CYC  = 1048576; // 2^20 system clocks
    localparam int          IDLE_W          = 21;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [3:0] res;
        logic       interp;
        logic       dual_edge;
    } ctrl_s;

    typedef struct packed {
        logic signed [8:0] a;
        logic signed [8:0] b;
    } coil_s;

endpackage

// >>> design/input_sync.sv
/*
  Two flip-flop synchroniser for a group of level inputs.
  Assumes the inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Levels in and out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // First stage is read only by the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

// >>> design/quarter_sine.sv
/*
  Full-circle sine from a stored quarter wave of 256 entries, peak 248.
  Assumes a 10-bit angle: upper two bits pick the quadrant.
*/
`timescale 1ns/1ps
module quarter_sine (
    // Angle in
    input  wire logic [9:0]       angle,
    // Signed current target out
    output logic signed [8:0]     value
);

    // ==========================================================
    // Quarter wave, entry 0 in the lowest byte
    localparam logic [2047:0] QUARTER_TBL = {
        256'hF8F8F8F8F8F8F8F8F8F8F7F7F7F7F7F7F7F7F6F6F6F6F6F5F5F5F5F4F4F4F4F3,
        256'hF3F3F2F2F2F1F1F1F0F0F0EFEFEEEEEEEDEDECECEBEBEAEAE9E9E8E8E7E7E6E5,
        256'hE5E4E4E3E2E2E1E1E0DFDFDEDDDCDCDBDADAD9D8D7D7D6D5D4D4D3D2D1D0CFCF,
        256'hCECDCCCBCAC9C9C8C7C6C5C4C3C2C1C0BFBEBDBCBBBAB9B8B7B6B5B4B3B2B1B0,
        256'hAFAEADACAAA9A8A7A6A5A4A3A1A09F9E9D9C9A99989796949392918F8E8D8C8A,
        256'h89888785848381807F7E7C7B7A787776747372706F6D6C6B6968676564626160,
        256'h5E5D5B5A595756545351504F4D4C4A494746444341403E3D3C3A393736343331,
        256'h302E2D2B2A2827252422211F1E1C1B191816151311100E0D0B0A080705040201
    };

    logic [7:0] index;
    logic [7:0] mag;

    // Mirror the descending quarters, negate the lower half circle
    always_comb begin
        index = angle[8] ? ~angle[7:0] : angle[7:0];
        mag   = QUARTER_TBL[{index, 3'h0} +: 8];
        value = angle[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    end

endmodule

// >>> sim/step_source.sv
/*
  Step source model: turns one-cycle requests into step and direction pin levels.
  Assumes the bench raises go for one clk cycle, at least eight cycles apart.
*/
`timescale 1ns/1ps
module step_source (
    // Clock and requests
    input  wire logic clk,
    input  wire logic go,
    input  wire logic toggle,
    input  wire logic dir_req,
    // Pins toward the sequencer
    output logic      step,
    output logic      dir
);
    // ==========
    // Sequencing
    int phase = 0;
    initial step = 1'b0;
    initial dir = 1'b0;
    // Direction settles two cycles before the edge; a pulse is held two cycles, a toggled level until the next request
    always @(posedge clk) begin
        if (go) begin
            dir   <= dir_req;
            phase <= 1;
        end else if (phase == 2) begin
            step  <= toggle ? ~step : 1'b1;
            phase <= toggle ? 0 : 3;
        end else if (phase == 4) begin
            step  <= 1'b0;
            phase <= 0;
        end else if (phase != 0) begin
            phase <= phase + 1;
        end
    end
endmodule

// >>> sim/step_dir_microstep_sequencer_bench.sv
/*
  Self-checking bench for the microstep sequencer with an integer position model.
  Assumes a 50 ns ref_clk and a short standstill count of 64 cycles.
*/
`timescale 1ns/1ps
module step_dir_microstep_sequencer_bench;
    // ==========
    // Signals
    localparam int SS = 64;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic        reg_wr, reg_rd, step_in, dir_in, half_current_standstill;
    logic        go, tog, dreq, standstill_flag;
    logic [9:0]  microstep_position;
    stepdir_pkg::coil_s coil;
    int          errors, n_compared, mpos, r, k;

    // Clock at 20 MHz
    always #25 ref_clk = ~ref_clk;

    step_source u_step_source (.clk(ref_clk), .go(go), .toggle(tog), .dir_req(dreq),
        .step(step_in), .dir(dir_in));
    step_dir_microstep_sequencer #(.STANDSTILL_CYCLES(SS)) u_step_dir_microstep_sequencer (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step_in(step_in),
        .dir_in(dir_in), .half_current_standstill(half_current_standstill), .coil(coil),
        .microstep_position(microstep_position), .standstill_flag(standstill_flag));

    // ==========
    // Checking and closing
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Sparse quarter wave: only the indices the walk visits
    function automatic int tv(input int i);
        case (i)
            0: return 1;
            127: return 175;
            128: return 176;
            default: return 248;
        endcase
    endfunction
    function automatic int sn(input int p);
        case ((p & 1023) >> 8)
            0: return tv(p & 255);
            1: return tv(255 - (p & 255));
            2: return -tv(p & 255);
            default: return -tv(255 - (p & 255));
        endcase
    endfunction
    task automatic coil_chk(input int sh);
        chk("coil a", 32'(coil.a), 32'(sn(mpos) >>> sh));
        chk("coil b", 32'(coil.b), 32'(sn(mpos + 256) >>> sh));
    endtask

    // ==========
    // Bus and step drivers
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Pulse or toggle, then wait past the three-edge input latency
    task automatic stp(input logic d, input logic t, input int sz);
        @(posedge ref_clk);
        go   <= 1'b1;
        tog  <= t;
        dreq <= d;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (8) @(posedge ref_clk);
        mpos = (d ? mpos - sz : mpos + sz) & 1023;
        #1 chk("position", 32'(microstep_position), mpos);
    endtask

    // ==========
    // Main sequence
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, go, tog, dreq, half_current_standstill} = '0;
        errors = 0;
        n_compared = 0;
        mpos = 0;
        r = $urandom(32'h89BA);
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(stepdir_pkg::ADDR_STATUS);
        chk("status", v, 32'h0);
        coil_chk(0);
        $display("test reset done");
        // Eighth-turn steps visit every quadrant point
        wr(stepdir_pkg::ADDR_CTRL, 32'h10);
        for (k = 0; k < 8; k++) begin
            stp(1'b0, 1'b0, 128);
            coil_chk(0);
        end
        $display("test table walk done");
        // Idle until standstill, then the strap halves the targets
        half_current_standstill <= 1'b1;
        repeat (SS - 12) @(posedge ref_clk);
        chk("early flag", 32'(standstill_flag), 32'h0);
        for (k = 0; k < 24 && standstill_flag !== 1'b1; k++) @(posedge ref_clk);
        if (k == 24) begin
            errors++;
            print_verdict();
        end
        rd(stepdir_pkg::ADDR_STATUS);
        chk("status", v, 32'h1);
        coil_chk(1);
        stp(1'b1, 1'b0, 128);
        chk("flag clear", 32'(standstill_flag), 32'h0);
        coil_chk(0);
        half_current_standstill <= 1'b0;
        $display("test standstill done");
        // Random resolution, direction and edge mode
        repeat (24) begin
            r = $urandom % 16;
            k = $urandom % 2;
            wr(stepdir_pkg::ADDR_CTRL, 32'((r << 4) | k));
            dreq = 1'($urandom % 2);
            stp(dreq, k[0], r > 8 ? 1 : 256 >> r);
            if (k == 1) stp(dreq, 1'b1, r > 8 ? 1 : 256 >> r);
        end
        rd(4'hC);
        chk("unmapped", v, 32'h0);
        $display("test random steps done");
        // Interpolated steps at a 48-cycle period, coarse setting ignored
        wr(stepdir_pkg::ADDR_CTRL, 32'h2);
        rd(stepdir_pkg::ADDR_CTRL);
        chk("control", v, 32'h2);
        for (k = 0; k < 6; k++) begin
            @(posedge ref_clk);
            go  <= 1'b1;
            tog <= 1'b0;
            dreq <= 1'b0;
            @(posedge ref_clk);
            go <= 1'b0;
            repeat (46) @(posedge ref_clk);
        end
        repeat (16) @(posedge ref_clk);
        mpos = (mpos + 96) & 1023;
        #1 chk("interp position", 32'(microstep_position), mpos);
        $display("test interpolation done");
        print_verdict();
    end
endmodule
